//--- misc_ctrl.sv
/*
 * Miscellaneous system control register with APB slave, sticky event
 * status, mask and one level interrupt output.
 * Assumes a 20 MHz pclk, APB master, and that power-on and external
 * reset both drive presetn; the power-on flag is set from por_event.
 */
// Our own choice: the APB register port.
`timescale 1ns/1ns
`include "misc_ctrl_cfg.svh"

// How it works
// [RL1] Power-up sets the flag; writing zero clears it, writing one does nothing.
// [RL2] Sensitivity 00 fall+low, 01 fall, 10 rise, 11 both, for the pin.
// [RL3] Wired-OR sensitivity mirrors: 00 rise+high, 01 rise, 10 fall, 11 both.
// [RL4] Sensitivity bits change only while the CPU interrupt mask is set.
// [RL5] Reset clears both sensitivity bits: falling edge and low level.
// [RL6] Enable bit one activates the pin interrupt function; zero disables it.
// [RL7] Enable bit writes need the interrupt mask; reset sets it to one.
// [RL8] Modulator A period: slow 4096, fast 256 timer clocks.
// [RL9] Modulator B period: slow 4096, fast 256 timer clocks.
// [RL10] Modulator rate spans 256 down to 16 times overflow flag rate.
// [RL11] Software sets speed bits before loading modulator values.
// [RL12] Slow mode divides the bus by 8 more; otherwise oscillator over 2.
// [RL13] Reset and stop entry clear slow mode.
// [RL14] Writing one to watchdog bit clears counter and enables watchdog.
// [RL15] Writing zero to watchdog bit has no effect.
// [RL16] Any reset loads the watchdog bit from the factory option.
// [RL17] Wired-OR requests come from port B inputs, only while enabled.
// [RL18] Mask-gated bits sample the mask on the write cycle itself.
module misc_ctrl
(
    // APB slave
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [11:0]                 paddr,
    input  wire logic [31:0]                 pwdata,
    output misc_ctrl_pkg::apb_resp_type      apb_resp,
    // System inputs
    input  wire logic                        por_event,
    input  wire logic                        cpu_irq_mask,
    input  wire logic                        stop_entry,
    input  wire logic                        watchdog_enable_bit_option,
    input  wire logic                        watchdog_enable_bit_reset,
    input  wire logic                        ext_irq_edge,
    input  wire logic [7:0]                  port_b_pins,
    input  wire logic [7:0]                  port_b_dir,
    input  wire logic                        wired_or_irq_enable,
    // Control outputs
    output misc_ctrl_pkg::misc_reg_type      misc_reg,
    output misc_ctrl_pkg::sense_type         sense,
    output logic        [12:0]               plm_a_period,
    output logic        [12:0]               plm_b_period,
    output logic        [4:0]                bus_divide,
    output logic                             watchdog_enable_bit_clear,
    output logic                             wired_or_request,
    output logic                             ext_irq_active,
    output logic                             irq
);
    import misc_ctrl_pkg::*;

    state_type st;
    state_type next_st;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // Modulator period for a speed bit.
    function automatic logic [12:0] plm_period(input logic slow);
        plm_period = slow ? `PLM_SLOW_PERIOD : `PLM_FAST_PERIOD;
    endfunction : plm_period

    logic       wr_access;
    logic       rd_access;
    logic       wr_misc;
    logic [7:0] wd;
    logic       woi_any;

    // Completed APB accesses; a write lands only at the edge where pready stands high.
    // This keeps a one-shot write from being applied twice in a two-cycle access.
    assign wr_access = psel & penable & pwrite & st.resp.pready;
    assign rd_access = psel & penable & ~pwrite;
    assign wr_misc   = wr_access && (paddr == `ADDR_MISC);
    assign wd        = pwdata[7:0];
    assign woi_any   = |(port_b_pins & ~port_b_dir); // RL17

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------

    // Computes every register's next value in one place.
    always_comb
    begin
        next_st = st;
        next_st.resp.pready  = 1'b0;
        next_st.resp.pslverr = 1'b0;
        next_st.resp.prdata  = 32'h0000_0000;
        next_st.watchdog_enable_bit_clear   = 1'b0;

        // The factory option is caught on the first clock after release.
        if (!st.opt_taken)
        begin
            next_st.opt_taken                = 1'b1;
            next_st.misc.watchdog_enable_bit = watchdog_enable_bit_option; // RL16
        end

        if (wr_misc)
        begin
            if (!wd[`BIT_POR])
                next_st.misc.por_flag = 1'b0; // RL1
            if (cpu_irq_mask) // RL18
            begin
                next_st.misc.ext_irq_rise_select = wd[`BIT_RISE]; // RL4
                next_st.misc.ext_irq_fall_select = wd[`BIT_FALL]; // RL4
                next_st.misc.ext_irq_enable      = wd[`BIT_EXT_IRQ_ENABLE]; // RL7
            end
            next_st.misc.modulator_a_slow = wd[`BIT_SFA];
            next_st.misc.modulator_b_slow = wd[`BIT_SFB];
            next_st.misc.system_slow_mode = wd[`BIT_SM];
            if (wd[`BIT_WATCHDOG_ENABLE_BIT]) // RL15
            begin
                next_st.misc.watchdog_enable_bit = 1'b1; // RL14
                next_st.watchdog_enable_bit_clear               = 1'b1; // RL14
            end
        end

        // Stop entry wins over a same-cycle write of slow mode.
        if (stop_entry)
            next_st.misc.system_slow_mode = 1'b0; // RL13

        // A watchdog reset reloads only the watchdog bit.
        if (watchdog_enable_bit_reset)
            next_st.misc.watchdog_enable_bit = watchdog_enable_bit_option; // RL16

        // Power-on sets the flag and wins over a clearing write.
        if (por_event)
            next_st.misc.por_flag = 1'b1; // RL1

        // Status clear by writing one; a new event wins over the clear.
        if (wr_access && (paddr == `ADDR_IRQ_STATUS))
            next_st.status = st.status & ~pwdata[`ST_WIDTH-1:0];
        if (wr_access && (paddr == `ADDR_IRQ_MASK))
            next_st.mask = pwdata[`ST_WIDTH-1:0];
        if (ext_irq_edge && st.misc.ext_irq_enable)
            next_st.status[`ST_EXT] = 1'b1; // RL6
        if (st.woi_request)
            next_st.status[`ST_WOI] = 1'b1;
        if (st.watchdog_enable_bit_clear)
            next_st.status[`ST_WD_KICK] = 1'b1;

        // Read data and answer.
        if (psel && penable)
        begin
            next_st.resp.pready = 1'b1;
            if (rd_access)
            begin
                if (paddr == `ADDR_MISC)
                    next_st.resp.prdata = {24'h000000, st.misc};
                else if (paddr == `ADDR_IRQ_STATUS)
                    next_st.resp.prdata = {29'h0000000, st.status};
                else if (paddr == `ADDR_IRQ_MASK)
                    next_st.resp.prdata = {29'h0000000, st.mask};
                else
                    next_st.resp.pslverr = 1'b1;
            end
            else if ((paddr != `ADDR_MISC) && (paddr != `ADDR_IRQ_STATUS) &&
                     (paddr != `ADDR_IRQ_MASK))
                next_st.resp.pslverr = 1'b1;
        end
        if (st.resp.pready)
            next_st.resp.pready = 1'b0;

        // Derived controls.
        next_st.sense.ext_level = ~next_st.misc.ext_irq_rise_select & ~next_st.misc.ext_irq_fall_select; // RL2
        next_st.sense.ext_fall  = ~next_st.misc.ext_irq_rise_select | next_st.misc.ext_irq_fall_select;  // RL2
        next_st.sense.ext_rise  = next_st.misc.ext_irq_rise_select;                                        // RL2
        next_st.sense.woi_level = next_st.sense.ext_level;                                                 // RL3
        next_st.sense.woi_rise  = next_st.sense.ext_fall;                                                  // RL3
        next_st.sense.woi_fall  = next_st.sense.ext_rise;                                                  // RL3
        next_st.plm_a_period = plm_period(next_st.misc.modulator_a_slow); // RL8 RL10
        next_st.plm_b_period = plm_period(next_st.misc.modulator_b_slow); // RL9 RL10
        next_st.bus_divide   = next_st.misc.system_slow_mode ? `SLOW_DIVIDE : `NORMAL_DIVIDE; // RL12
        next_st.woi_request  = woi_any & wired_or_irq_enable; // RL17
        next_st.ext_irq_active = next_st.misc.ext_irq_enable; // RL6
        next_st.irq = |(next_st.status & next_st.mask);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------

    // Reset loads sensitivity clear, enable set, slow mode clear.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st                          <= '0;
            st.misc.ext_irq_enable      <= 1'b1;          // RL5 RL7
            st.misc.watchdog_enable_bit <= `WATCHDOG_ENABLE_BIT_OPTION_DEF;
            st.sense.ext_level          <= 1'b1;          // RL5
            st.sense.ext_fall           <= 1'b1;          // RL5
            st.sense.woi_level          <= 1'b1;
            st.sense.woi_rise           <= 1'b1;
            st.plm_a_period             <= `PLM_FAST_PERIOD;
            st.plm_b_period             <= `PLM_FAST_PERIOD;
            st.bus_divide               <= `NORMAL_DIVIDE;
            st.ext_irq_active           <= 1'b1;
        end
        else
            st <= next_st;
    end

    // Outputs come straight from the state register.
    assign apb_resp         = st.resp;
    assign misc_reg         = st.misc;
    assign sense            = st.sense;
    assign plm_a_period     = st.plm_a_period;
    assign plm_b_period     = st.plm_b_period;
    assign bus_divide       = st.bus_divide;
    assign watchdog_enable_bit_clear       = st.watchdog_enable_bit_clear;
    assign wired_or_request = st.woi_request;
    assign ext_irq_active   = st.ext_irq_active;
    assign irq              = st.irq;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_por_set_wins: assert property (por_event |=> st.misc.por_flag) // RL1
        else $error("power-on flag not set");
    a_por_no_sw_set: assert property (!st.misc.por_flag && !por_event |=> !st.misc.por_flag) // RL1
        else $error("power-on flag set by software");
    a_sense_gated: assert property (wr_misc && !cpu_irq_mask |=> $stable({st.misc.ext_irq_rise_select, st.misc.ext_irq_fall_select})) // RL4
        else $error("sensitivity changed without mask");
    a_ext_irq_enable_gated: assert property (wr_misc && !cpu_irq_mask |=> $stable(st.misc.ext_irq_enable)) // RL7
        else $error("enable changed without mask");
    a_sense_map: assert property (sense.ext_level == (!misc_reg.ext_irq_rise_select && !misc_reg.ext_irq_fall_select)) // RL2
        else $error("pin sensitivity wrong");
    a_woi_mirror: assert property (sense.woi_fall == misc_reg.ext_irq_rise_select) // RL3
        else $error("wired-OR sensitivity wrong");
    a_plm_period: assert property (plm_a_period == (misc_reg.modulator_a_slow ? `PLM_SLOW_PERIOD : `PLM_FAST_PERIOD)) // RL8
        else $error("modulator A period wrong");
    a_modulator_b_period: assert property (plm_b_period == (misc_reg.modulator_b_slow ? `PLM_SLOW_PERIOD : `PLM_FAST_PERIOD)) // RL9
        else $error("modulator B period wrong");
    a_stop_clears: assert property (stop_entry |=> !st.misc.system_slow_mode ##0 bus_divide == `NORMAL_DIVIDE) // RL13
        else $error("stop did not clear slow mode");
    a_watchdog_enable_bit_kick: assert property (wr_misc && wd[`BIT_WATCHDOG_ENABLE_BIT] && !watchdog_enable_bit_reset |=> watchdog_enable_bit_clear && st.misc.watchdog_enable_bit) // RL14
        else $error("watchdog kick missing");
    a_watchdog_enable_bit_hold: assert property (st.misc.watchdog_enable_bit && !watchdog_enable_bit_reset |=> st.misc.watchdog_enable_bit) // RL15
        else $error("watchdog disabled by software");
    a_woi_gate: assert property (!wired_or_irq_enable |=> !wired_or_request) // RL17
        else $error("wired-OR request while disabled");

    c_por_clear: cover property (st.misc.por_flag ##1 !st.misc.por_flag);
    c_sense_write: cover property (wr_misc && cpu_irq_mask ##1 misc_reg.ext_irq_rise_select);
    c_watchdog_enable_bit_kick: cover property (watchdog_enable_bit_clear);
    c_irq: cover property (irq);

endmodule : misc_ctrl

//--- misc_ctrl_cfg.svh
/*
 * Constants for the miscellaneous system control register block.
 * Assumes inclusion by the package and the design module.
 */
`ifndef MISC_CTRL_CFG_SVH
`define MISC_CTRL_CFG_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define ADDR_MISC        12'h00c
`define ADDR_IRQ_STATUS  12'h010
`define ADDR_IRQ_MASK    12'h014
`define ADDR_STROBES     12'h018

// ----------------------------------------------------------------
// Bit positions in the control register
// ----------------------------------------------------------------
`define BIT_POR      7
`define BIT_RISE     6
`define BIT_FALL     5
`define BIT_EXT_IRQ_ENABLE     4
`define BIT_SFA      3
`define BIT_SFB      2
`define BIT_SM       1
`define BIT_WATCHDOG_ENABLE_BIT     0

// ----------------------------------------------------------------
// Status bit positions
// ----------------------------------------------------------------
`define ST_EXT       0
`define ST_WOI       1
`define ST_WD_KICK   2
`define ST_WIDTH     3

// ----------------------------------------------------------------
// Timing: modulator period in timer clocks, slow-mode bus divide
// ----------------------------------------------------------------
`define PLM_SLOW_PERIOD 13'h1000
`define PLM_FAST_PERIOD 13'h0100
`define SLOW_DIVIDE     5'h10
`define NORMAL_DIVIDE   5'h02
`define WATCHDOG_ENABLE_BIT_OPTION_DEF 1'b0

`endif

//--- misc_ctrl_pkg.sv
/*
 * Types for the miscellaneous system control register block.
 * Assumes misc_ctrl_cfg.svh is on the include path.
 */
`include "misc_ctrl_cfg.svh"

package misc_ctrl_pkg;

    // ------------------------------------------------------------
    // Control register fields, bit 7 down to bit 0
    // ------------------------------------------------------------
    typedef struct packed {
        logic por_flag;
        logic ext_irq_rise_select;
        logic ext_irq_fall_select;
        logic ext_irq_enable;
        logic modulator_a_slow;
        logic modulator_b_slow;
        logic system_slow_mode;
        logic watchdog_enable_bit;
    } misc_reg_type;

    // APB response bundle.
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } apb_resp_type;

    // Interrupt sensitivity outputs for the pin and the port B logic.
    typedef struct packed {
        logic ext_level;
        logic ext_fall;
        logic ext_rise;
        logic woi_level;
        logic woi_rise;
        logic woi_fall;
    } sense_type;

    // Whole block state.
    typedef struct packed {
        misc_reg_type                 misc;
        logic [`ST_WIDTH-1:0]         status;
        logic [`ST_WIDTH-1:0]         mask;
        apb_resp_type                 resp;
        logic                         irq;
        logic                         watchdog_enable_bit_clear;
        sense_type                    sense;
        logic [12:0]                  plm_a_period;
        logic [12:0]                  plm_b_period;
        logic [4:0]                   bus_divide;
        logic                         woi_request;
        logic                         ext_irq_active;
        logic                         opt_taken;
    } state_type;

endpackage : misc_ctrl_pkg

//--- test_misc_ctrl.sv
/*
 * Self-checking testbench for the miscellaneous system control register block.
 * Assumes misc_ctrl_pkg and misc_ctrl are compiled first; pclk runs at 20 MHz.
 */
`timescale 1ns/1ns

module test_misc_ctrl;
    import misc_ctrl_pkg::*;

    // ----------------------------------------------------------------
    // Signals and bookkeeping
    // ----------------------------------------------------------------
    typedef struct packed {logic wr; logic [31:0] data; logic err;} note_type;
    logic         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0]  paddr = 12'h000;
    logic [31:0]  pwdata = 32'h0;
    logic         por_event = 1'b0, cpu_irq_mask = 1'b0, stop_entry = 1'b0, watchdog_enable_bit_option = 1'b1;
    logic         watchdog_enable_bit_reset = 1'b0, ext_irq_edge = 1'b0, wired_or_irq_enable = 1'b0;
    logic [7:0]   port_b_pins = 8'h00, port_b_dir = 8'hff;
    apb_resp_type apb_resp;
    misc_reg_type misc_reg, m;
    sense_type    sense;
    logic [12:0]  plm_a_period, plm_b_period;
    logic [4:0]   bus_divide;
    logic         watchdog_enable_bit_clear, wired_or_request, ext_irq_active, irq;
    note_type     notes[$];
    note_type     nt;
    int           n_mismatch = 0, n_checks = 0, n_clear = 0, clear_base = 0;
    logic         woi_seen = 1'b0;
    logic [1:0]   code;

    misc_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .apb_resp(apb_resp), .por_event(por_event),
        .cpu_irq_mask(cpu_irq_mask), .stop_entry(stop_entry), .watchdog_enable_bit_option(watchdog_enable_bit_option),
        .watchdog_enable_bit_reset(watchdog_enable_bit_reset), .ext_irq_edge(ext_irq_edge), .port_b_pins(port_b_pins),
        .port_b_dir(port_b_dir), .wired_or_irq_enable(wired_or_irq_enable), .misc_reg(misc_reg),
        .sense(sense), .plm_a_period(plm_a_period), .plm_b_period(plm_b_period),
        .bus_divide(bus_divide), .watchdog_enable_bit_clear(watchdog_enable_bit_clear), .wired_or_request(wired_or_request),
        .ext_irq_active(ext_irq_active), .irq(irq));

    // The clock toggles every half period of 25 ns.
    always #25 pclk = ~pclk;

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // One APB transfer; the expected answer is noted for the monitor.
    task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                            input logic [31:0] exp, input logic err);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
        notes.push_back('{wr, exp, err});
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end while (apb_resp.pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb_xfer

    // Compares every port that follows the control register with the mirror.
    task automatic check_outputs();
        code = {m.ext_irq_rise_select, m.ext_irq_fall_select};
        repeat (2) @(posedge pclk);
        chk("misc_reg", 32'(m), 32'(misc_reg));
        chk("sense", 32'({code == 2'd0, code != 2'd2, code[1]}), 32'(sense[5:3]));
        chk("woi sense", 32'({code == 2'd0, code != 2'd2, code[1]}), 32'(sense[2:0]));
        chk("plm_a", m.modulator_a_slow ? 32'h1000 : 32'h0100, 32'(plm_a_period));
        chk("plm_b", m.modulator_b_slow ? 32'h1000 : 32'h0100, 32'(plm_b_period));
        chk("bus_divide", m.system_slow_mode ? 32'h10 : 32'h02, 32'(bus_divide));
        chk("ext_active", 32'(m.ext_irq_enable), 32'(ext_irq_active));
        apb_xfer(1'b0, 12'h00c, 32'h0, 32'(m), 1'b0);
    endtask : check_outputs

    // Writes the control register and updates the mirror by the bit rules.
    task automatic wr_misc(input logic [7:0] d);
        apb_xfer(1'b1, 12'h00c, {24'h0, d}, 32'h0, 1'b0);
        m.por_flag = m.por_flag & d[7];
        if (cpu_irq_mask) {m.ext_irq_rise_select, m.ext_irq_fall_select, m.ext_irq_enable} = d[6:4];
        {m.modulator_a_slow, m.modulator_b_slow, m.system_slow_mode} = d[3:1];
        m.watchdog_enable_bit = m.watchdog_enable_bit | d[0];
        check_outputs();
    endtask : wr_misc

    task automatic do_reset();
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        m = {1'b0, 3'b001, 3'b000, watchdog_enable_bit_option};
    endtask : do_reset

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : final_report

    // ----------------------------------------------------------------
    // Monitor: each answer is matched with the oldest note
    // ----------------------------------------------------------------
    always @(posedge pclk)
    begin
        if (watchdog_enable_bit_clear === 1'b1) n_clear++;
        if (apb_resp.pready === 1'b1 && notes.size() == 0)
        begin
            n_mismatch++;
            $display("mismatch pready expected 0 seen 1");
        end
        else if (apb_resp.pready === 1'b1)
        begin
            nt = notes.pop_front();
            chk("pslverr", 32'(nt.err), 32'(apb_resp.pslverr));
            if (!nt.wr) chk("prdata", nt.data, apb_resp.prdata);
        end
    end

    // The watchdog cuts a hang short well after the tests should be over.
    initial
    begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        final_report();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        void'($urandom(34682));
        do_reset();
        check_outputs();
        @(posedge pclk) por_event <= 1'b1;
        @(posedge pclk) por_event <= 1'b0;
        m.por_flag = 1'b1;
        check_outputs();
        wr_misc(8'h61);
        wr_misc(8'h80);
        cpu_irq_mask <= 1'b1;
        for (int i = 0; i < 8; i++) wr_misc({1'b0, i[1:0], i[2], 3'($urandom), 1'b0});
        wr_misc(8'h1e);
        @(posedge pclk) stop_entry <= 1'b1;
        @(posedge pclk) stop_entry <= 1'b0;
        m.system_slow_mode = 1'b0;
        check_outputs();
        // Pin event, masking and clearing of the sticky status.
        apb_xfer(1'b1, 12'h014, 32'h1, 32'h0, 1'b0);
        @(posedge pclk) ext_irq_edge <= 1'b1;
        @(posedge pclk) ext_irq_edge <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("irq", 32'h1, 32'(irq));
        // Bit 2 is still set from the watchdog kick of the first control write.
        apb_xfer(1'b0, 12'h010, 32'h0, 32'h5, 1'b0);
        apb_xfer(1'b1, 12'h014, 32'h0, 32'h0, 1'b0);
        repeat (3) @(posedge pclk);
        chk("irq masked", 32'h0, 32'(irq));
        apb_xfer(1'b1, 12'h010, 32'h7, 32'h0, 1'b0);
        apb_xfer(1'b0, 12'h010, 32'h0, 32'h0, 1'b0);
        wr_misc(8'h00);
        @(posedge pclk) ext_irq_edge <= 1'b1;
        @(posedge pclk) ext_irq_edge <= 1'b0;
        apb_xfer(1'b0, 12'h010, 32'h0, 32'h0, 1'b0);
        // Wired-OR request from port B inputs under its enable.
        for (int i = 0; i < 6; i++)
        begin
            @(posedge pclk);
            port_b_pins <= 8'($urandom);
            port_b_dir <= 8'($urandom);
            wired_or_irq_enable <= i[0];
            repeat (3) @(posedge pclk);
            chk("wired_or", 32'(|(port_b_pins & ~port_b_dir) & wired_or_irq_enable), 32'(wired_or_request));
            woi_seen = woi_seen | (|(port_b_pins & ~port_b_dir) & wired_or_irq_enable);
        end
        apb_xfer(1'b0, 12'h010, 32'h0, {30'h0, woi_seen, 1'b0}, 1'b0);
        apb_xfer(1'b0, 12'h018, 32'h0, 32'h0, 1'b1);
        apb_xfer(1'b1, 12'h018, 32'hff, 32'h0, 1'b1);
        // Watchdog bit from a disabled option, set once, then reloaded.
        watchdog_enable_bit_option <= 1'b0;
        do_reset();
        check_outputs();
        clear_base = n_clear;
        wr_misc(8'h11);
        chk("watchdog_enable_bit_clear", 32'h1, 32'(n_clear - clear_base));
        wr_misc(8'h10);
        @(posedge pclk) watchdog_enable_bit_reset <= 1'b1;
        @(posedge pclk) watchdog_enable_bit_reset <= 1'b0;
        m.watchdog_enable_bit = 1'b0;
        check_outputs();
        final_report();
    end
endmodule : test_misc_ctrl
